// [abs_ab_signaling.sv]
// Signaling card core: host bus slave, RAM arbiter, shared RAMs and the
// serial driver and receiver facing the time switch.
// Assumes all inputs synchronous to clk and the host bus pins resolved
// from the output enable outside this module.
`timescale 1ns/10ps
`default_nettype none
`include "abs_defines.svh"

// Overview of operation
// - Host access aligned to internal memory cycles.
// - Arbiter grants RAMs to host or microprocessor.
// - Outgoing RAM stores host A-bits as bytes.
// - Words are sent most significant bit first.
// - Timing unit schedules transmit and receive slots.
// - B-words sent as microprocessor encoded them.
// - Incoming RAM records latest received A-bits.
// - Incoming B-words held until microprocessor reads.
// - Command RAM shared by host and microprocessor.
// - Command and outgoing regions share one memory.
// - Driver serializes outgoing words to the line.
// - Receiver assembles serial input into words.
// - Card drives data only during host reads.
// - Board select bits compared with upper address.
// - Card generates the transfer acknowledge.
// - One outgoing and one incoming serial line.
module abs_ab_signaling #(
	parameter int AW = 6, // Log2 of words per region.
	parameter int A_WORDS = 32, // Incoming words holding A-bits.
	parameter int BIT_DIV = 8, // Clocks per serial bit slot.
	parameter int BOARD_W = 3 // Width of the board select field.
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic masterResetN,
	input wire logic frameSync,
	input wire logic masterFramePulse,
	input wire logic [`ABS_ADDR_W-1:0] hostAddr,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	input wire logic addrValidStrobeN,
	input wire logic upperByteStrobeN,
	input wire logic lowerByteStrobeN,
	input wire logic hostRead,
	output logic transferAckN,
	input wire logic [BOARD_W-1:0] boardSelectBits,
	input wire logic upReq,
	input wire logic upWrite,
	input wire logic [AW+1:0] upAddr,
	input wire logic [7:0] upWrData,
	output logic [7:0] upRdData,
	output logic upAck,
	output logic sigSerialOut,
	input wire logic sigSerialIn
);
	localparam int DEPTH = 1 << AW;
	localparam int DW = $clog2(BIT_DIV) + 1;

	// =========================================================
	// Shared memories
	// Command and outgoing regions sit in one array, split by the top
	// index bit; incoming words have their own array.
	abs_pkg::abs_byte_t cmdOutRam [2*DEPTH];
	abs_pkg::abs_byte_t inRam [DEPTH];

	// Index into the command/outgoing array for a region and word.
	function automatic logic [AW:0] ramIndex(input logic [1:0] region,
			input logic [AW-1:0] idx);
		ramIndex = {region == `ABS_REG_OUT, idx};
	endfunction

	// =========================================================
	// Host sequencer state
	abs_pkg::abs_host_e hostState;
	abs_pkg::abs_host_e next_hostState;
	logic [7:0] next_hostDataOut;
	logic next_hostDataOe;
	logic next_transferAckN;
	logic hostSel; // Card addressed with a data strobe active.
	logic strobesIdle; // Both data strobes released.

	// Arbiter and access port.
	logic lastHost; // Host had the last contested grant.
	logic next_lastHost;
	logic hostWant;
	logic upWant;
	logic grantHost;
	logic grantUp;
	logic [1:0] accRegion;
	logic [AW-1:0] accIdx;
	logic accWrite;
	logic [7:0] accWrData;
	logic [7:0] accRdData;
	logic [7:0] next_upRdData;
	logic next_upAck;

	// Address decode: board match on the top lines, then region.
	assign hostSel = !addrValidStrobeN && (!upperByteStrobeN ||
		!lowerByteStrobeN) && (hostAddr[`ABS_ADDR_W-1 -: BOARD_W] ==
		boardSelectBits);
	assign strobesIdle = upperByteStrobeN && lowerByteStrobeN;

	// Arbiter: one access per memory cycle, alternating on contention.
	always_comb begin
		hostWant = (hostState == abs_pkg::ABS_HS_ACCESS);
		upWant = upReq && !upAck;
		grantHost = hostWant && (!upWant || !lastHost);
		grantUp = upWant && !grantHost;
		next_lastHost = lastHost;
		if (hostWant && upWant) begin
			next_lastHost = grantHost;
		end
		if (grantHost) begin
			accRegion = hostAddr[`ABS_SEL_LO+1:`ABS_SEL_LO];
			accIdx = hostAddr[AW-1:0];
			accWrite = !hostRead;
			accWrData = hostDataIn;
		end else begin
			accRegion = upAddr[AW+1:AW];
			accIdx = upAddr[AW-1:0];
			accWrite = upWrite;
			accWrData = upWrData;
		end
		// Read side of the access port.
		if (accRegion == `ABS_REG_IN) begin
			accRdData = inRam[accIdx];
		end else if (accRegion == `ABS_REG_CMD ||
				accRegion == `ABS_REG_OUT) begin
			accRdData = cmdOutRam[ramIndex(accRegion, accIdx)];
		end else begin
			accRdData = `ABS_UNMAPPED;
		end
	end

	// Host sequencer: wait for a grant, then acknowledge until release.
	always_comb begin
		next_hostState = hostState;
		next_hostDataOut = hostDataOut;
		next_hostDataOe = hostDataOe;
		next_transferAckN = transferAckN;
		next_upRdData = upRdData;
		next_upAck = grantUp;
		if (grantUp && !upWrite) begin
			next_upRdData = accRdData;
		end
		unique case (hostState)
			abs_pkg::ABS_HS_IDLE: begin
				// A strobe only starts a request; the RAM is touched later,
				// in a granted memory cycle.
				if (hostSel) begin
					next_hostState = abs_pkg::ABS_HS_ACCESS;
				end
			end
			abs_pkg::ABS_HS_ACCESS: begin
				if (grantHost) begin
					next_hostState = abs_pkg::ABS_HS_ACK;
					next_hostDataOut = accRdData;
					next_hostDataOe = hostRead;
					next_transferAckN = 1'b0;
				end
			end
			abs_pkg::ABS_HS_ACK: begin
				if (strobesIdle || addrValidStrobeN) begin
					next_hostState = abs_pkg::ABS_HS_IDLE;
					next_hostDataOe = 1'b0;
					next_transferAckN = `ABS_ACK_IDLE;
				end
			end
		endcase
		if (!masterResetN) begin
			next_hostState = abs_pkg::ABS_HS_IDLE;
			next_hostDataOe = 1'b0;
			next_transferAckN = `ABS_ACK_IDLE;
			next_upAck = 1'b0;
		end
	end

	// Register host sequencer and arbiter state.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hostState <= abs_pkg::ABS_HS_IDLE;
			hostDataOut <= 8'h00;
			hostDataOe <= 1'b0;
			transferAckN <= `ABS_ACK_IDLE;
			lastHost <= 1'b0;
			upRdData <= 8'h00;
			upAck <= 1'b0;
		end else if (clkEn) begin
			hostState <= next_hostState;
			hostDataOut <= next_hostDataOut;
			hostDataOe <= next_hostDataOe;
			transferAckN <= next_transferAckN;
			lastHost <= next_lastHost;
			upRdData <= next_upRdData;
			upAck <= next_upAck;
		end
	end

	// =========================================================
	// Timing unit
	// Bit slots are counted from the frame sync so driver and receiver
	// stay aligned with the time switch frame.
	logic [DW-1:0] divCnt;
	logic [DW-1:0] next_divCnt;
	logic bitTick;
	logic next_bitTick;

	// Next bit-slot counter and tick.
	always_comb begin
		next_divCnt = divCnt + 1'b1;
		next_bitTick = 1'b0;
		if (frameSync || !masterResetN) begin
			next_divCnt = '0;
		end else if (divCnt == DW'(BIT_DIV - 1)) begin
			next_divCnt = '0;
			next_bitTick = 1'b1;
		end
	end

	// Register the timing unit.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt <= '0;
			bitTick <= 1'b0;
		end else if (clkEn) begin
			divCnt <= next_divCnt;
			bitTick <= next_bitTick;
		end
	end

	// =========================================================
	// Driver and receiver
	logic [AW-1:0] txIndex; // Next outgoing word to fetch.
	logic [7:0] txShift; // Remaining bits of the word on the line.
	logic [2:0] txLeft; // Bits still to send after the current one.
	logic [AW-1:0] rxIndex; // Incoming word being assembled.
	logic [7:0] rxShift;
	logic [2:0] rxCount;
	logic [DEPTH-1:0] held; // B-word waiting for the microprocessor.
	logic [AW-1:0] next_txIndex;
	logic [7:0] next_txShift;
	logic [2:0] next_txLeft;
	logic next_sigSerialOut;
	logic [AW-1:0] next_rxIndex;
	logic [7:0] next_rxShift;
	logic [2:0] next_rxCount;
	logic [DEPTH-1:0] next_held;
	logic bufInReady;
	logic bufOutValid;
	logic bufOutReady;
	logic [7:0] bufOutData;
	logic rxStore; // Completed word may be written this cycle.
	logic flushTx;

	// A master frame restarts both word streams at word zero.
	assign flushTx = masterFramePulse || !masterResetN;
	// The driver pulls a new word only at the start of a bit slot.
	assign bufOutReady = bitTick && (txLeft == 3'h0);

	// Prefetched outgoing words wait here, so a late slot loses none.
	abs_pair_buffer #(
		.W(8)
	) txBuffer (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.flush(flushTx),
		.inValid(1'b1),
		.inReady(bufInReady),
		.inData(cmdOutRam[ramIndex(`ABS_REG_OUT, txIndex)]),
		.outValid(bufOutValid),
		.outReady(bufOutReady),
		.outData(bufOutData)
	);

	// Next values of the serial engines and the B-word hold flags.
	always_comb begin
		next_txIndex = txIndex;
		next_txShift = txShift;
		next_txLeft = txLeft;
		next_sigSerialOut = sigSerialOut;
		next_rxIndex = rxIndex;
		next_rxShift = rxShift;
		next_rxCount = rxCount;
		next_held = held;
		rxStore = 1'b0;
		if (bufInReady) begin
			next_txIndex = txIndex + 1'b1;
		end
		if (bitTick) begin
			if (txLeft != 3'h0) begin
				next_sigSerialOut = txShift[`ABS_BYTE_MSB];
				next_txShift = {txShift[6:0], 1'b0};
				next_txLeft = txLeft - 1'b1;
			end else if (bufOutValid) begin
				// Parallel word in, first bit out on the same slot.
				next_sigSerialOut = bufOutData[`ABS_BYTE_MSB];
				next_txShift = {bufOutData[6:0], 1'b0};
				next_txLeft = `ABS_BITS_LAST;
			end else begin
				next_sigSerialOut = `ABS_LINE_IDLE;
			end
			next_rxShift = {rxShift[6:0], sigSerialIn};
			next_rxCount = rxCount + 1'b1;
			if (rxCount == `ABS_BITS_LAST) begin
				next_rxIndex = rxIndex + 1'b1;
				// A-bit words always take the newest value; a held B-word
				// is kept unless it is being read in this very cycle.
				rxStore = (32'(rxIndex) < A_WORDS) || !held[rxIndex] ||
					(grantUp && !upWrite && accRegion == `ABS_REG_IN &&
					accIdx == rxIndex);
			end
		end
		// Microprocessor read of a B-word releases it.
		if (grantUp && !upWrite && accRegion == `ABS_REG_IN) begin
			next_held[accIdx] = 1'b0;
		end
		// Set after clear, so a new word wins over the release.
		if (rxStore && 32'(rxIndex) >= A_WORDS) begin
			next_held[rxIndex] = 1'b1;
		end
		if (flushTx) begin
			next_txIndex = '0;
			next_txLeft = 3'h0;
			next_rxIndex = '0;
			next_rxCount = 3'h0;
		end
		if (frameSync) begin
			next_rxCount = 3'h0;
		end
		if (!masterResetN) begin
			next_sigSerialOut = `ABS_LINE_IDLE;
			next_held = '0;
		end
	end

	// Register the serial engines.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			txIndex <= '0;
			txShift <= 8'h00;
			txLeft <= 3'h0;
			sigSerialOut <= `ABS_LINE_IDLE;
			rxIndex <= '0;
			rxShift <= 8'h00;
			rxCount <= 3'h0;
			held <= '0;
		end else if (clkEn) begin
			txIndex <= next_txIndex;
			txShift <= next_txShift;
			txLeft <= next_txLeft;
			sigSerialOut <= next_sigSerialOut;
			rxIndex <= next_rxIndex;
			rxShift <= next_rxShift;
			rxCount <= next_rxCount;
			held <= next_held;
		end
	end

	// Memory writes: the access port may not write incoming words, which
	// belong to the receiver alone.
	always_ff @(posedge clk) begin
		if (clkEn) begin
			if ((grantHost || grantUp) && accWrite &&
					(accRegion == `ABS_REG_CMD ||
					accRegion == `ABS_REG_OUT)) begin
				cmdOutRam[ramIndex(accRegion, accIdx)] <= accWrData;
			end
			if (rxStore && masterResetN) begin
				inRam[rxIndex] <= next_rxShift;
			end
		end
	end
endmodule

`default_nettype wire

// [abs_defines.svh]
// Constants of the A-bit/B-word signaling interface: address fields,
// region codes, serial word layout and reset values.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ABS_DEFINES_SVH
`define ABS_DEFINES_SVH

// Host address bus width, lines 1 to 21.
`define ABS_ADDR_W 21
// Lowest address bit of the two-bit region field.
`define ABS_SEL_LO 8
// Region codes seen by host and microprocessor.
`define ABS_REG_CMD 2'h0
`define ABS_REG_OUT 2'h1
`define ABS_REG_IN 2'h2
// Serial words are one byte, most significant bit first.
`define ABS_BYTE_MSB 7
`define ABS_BITS_LAST 3'h7
// Reset value of the active-low acknowledge and of the line.
`define ABS_ACK_IDLE 1'b1
`define ABS_LINE_IDLE 1'b0
// Read answer for an unmapped region.
`define ABS_UNMAPPED 8'h00

`endif

// [abs_pkg.sv]
// Types shared by the signaling interface design files.
// Assumes the defines header is compiled alongside.
package abs_pkg;
	// One-hot states of the host access sequencer.
	typedef enum logic [2:0] {
		ABS_HS_IDLE = 3'b001,
		ABS_HS_ACCESS = 3'b010,
		ABS_HS_ACK = 3'b100
	} abs_host_e;
	// One signaling word.
	typedef logic [7:0] abs_byte_t;
endpackage

// [abs_pair_buffer.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, the block's clock enable and a synchronous flush.
`timescale 1ns/10ps
`default_nettype none

module abs_pair_buffer #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	// =========================================================
	// Storage and pointers
	logic [W-1:0] slot [2]; // The two entries.
	logic wrPtr; // Next entry to fill.
	logic rdPtr; // Next entry to drain.
	logic [1:0] count; // Entries held, zero to two.
	logic next_wrPtr;
	logic next_rdPtr;
	logic [1:0] next_count;
	logic push;
	logic pop;

	// Full and empty come straight from the count, so they never lie.
	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = slot[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Next pointer and count values; flush empties the buffer.
	always_comb begin
		next_wrPtr = wrPtr ^ push;
		next_rdPtr = rdPtr ^ pop;
		next_count = count + 2'(push) - 2'(pop);
		if (flush) begin
			next_wrPtr = 1'b0;
			next_rdPtr = 1'b0;
			next_count = 2'h0;
		end
	end

	// Register pointers and count.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
		end else if (clkEn) begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end

	// Entry storage carries no reset; it is only read when counted valid.
	always_ff @(posedge clk) begin
		if (clkEn && push && !flush) begin
			slot[wrPtr] <= inData;
		end
	end
endmodule

`default_nettype wire

// [abs_ab_signaling_monitor.sv]
// Checker for the signaling core: host handshake, arbiter answers and
// master reset, judged from the core's ports only.
// Assumes the host holds each request until it is acknowledged.
`timescale 1ns/10ps
`default_nettype none
`include "abs_defines.svh"

module abs_ab_signaling_monitor #(
	parameter int AW = 6,
	parameter int A_WORDS = 32,
	parameter int BIT_DIV = 8,
	parameter int BOARD_W = 3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic masterResetN,
	input wire logic [`ABS_ADDR_W-1:0] hostAddr,
	input wire logic hostRead,
	input wire logic addrValidStrobeN,
	input wire logic upperByteStrobeN,
	input wire logic lowerByteStrobeN,
	input wire logic [BOARD_W-1:0] boardSelectBits,
	input wire logic transferAckN,
	input wire logic hostDataOe,
	input wire logic upReq,
	input wire logic upAck,
	input wire logic sigSerialOut
);
	// =====================================================
	// A host request aimed at this board, at least one data strobe low.
	logic hostReq;
	assign hostReq = !addrValidStrobeN && hostAddr[`ABS_ADDR_W-1 -: BOARD_W]
		== boardSelectBits && !(upperByteStrobeN && lowerByteStrobeN);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// =====================================================
	// Host bus; a contested access may cost one extra cycle.
	property p_ackLate;
		$rose(hostReq) && transferAckN |-> ##[2:4] !transferAckN;
	endproperty
	a_ackLate: assert property (p_ackLate)
		else $error("host acknowledge late");
	property p_ackCause; $fell(transferAckN) |-> hostReq; endproperty
	a_ackCause: assert property (p_ackCause)
		else $error("acknowledge without matching request");
	property p_ackDrop;
		!transferAckN && upperByteStrobeN && lowerByteStrobeN |=> transferAckN;
	endproperty
	a_ackDrop: assert property (p_ackDrop)
		else $error("acknowledge kept after strobe release");
	property p_oeDir; $fell(transferAckN) |-> hostDataOe == hostRead; endproperty
	a_oeDir: assert property (p_oeDir)
		else $error("data drive does not follow direction");
	property p_oeRead; hostDataOe |-> hostRead && !transferAckN; endproperty
	a_oeRead: assert property (p_oeRead)
		else $error("data driven outside a read");
	// =====================================================
	// Arbiter answers to the microprocessor.
	property p_upPulse; upAck |=> !upAck; endproperty
	a_upPulse: assert property (p_upPulse)
		else $error("grant answer longer than one cycle");
	property p_upWait; $rose(upReq) |-> ##[1:4] upAck; endproperty
	a_upWait: assert property (p_upWait)
		else $error("microprocessor starved");
	property p_mRst;
		!masterResetN |=> transferAckN && !hostDataOe && !upAck && !sigSerialOut;
	endproperty
	a_mRst: assert property (p_mRst)
		else $error("master reset left outputs active");
	c_read: cover property ($fell(transferAckN) && hostRead);
	c_write: cover property ($fell(transferAckN) && !hostRead);
	c_both: cover property ($rose(upReq) && hostReq && transferAckN);
endmodule

bind abs_ab_signaling abs_ab_signaling_monitor #(.AW(AW), .A_WORDS(A_WORDS),
	.BIT_DIV(BIT_DIV), .BOARD_W(BOARD_W)) mon_u (.clk(clk), .sys_rst(sys_rst),
	.masterResetN(masterResetN), .hostAddr(hostAddr), .hostRead(hostRead),
	.addrValidStrobeN(addrValidStrobeN), .upperByteStrobeN(upperByteStrobeN),
	.lowerByteStrobeN(lowerByteStrobeN), .boardSelectBits(boardSelectBits),
	.transferAckN(transferAckN), .hostDataOe(hostDataOe), .upReq(upReq),
	.upAck(upAck), .sigSerialOut(sigSerialOut));
`default_nettype wire

// [abs_time_switch_model.sv]
// Time switch model: frame pulses, a steady incoming pattern and a
// catcher that rebuilds outgoing bytes from the serial line.
// Assumes the core's first bit slot opens BIT_DIV + 1 clocks after the
// edge at which it samples the sync, and that one sync starts a run.
`timescale 1ns/10ps
`default_nettype none

module abs_time_switch_model #(
	parameter int BIT_DIV = 8,
	parameter logic [7:0] IN_BYTE = 8'hFF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	output logic frameSync,
	output logic masterFramePulse,
	output logic sigSerialIn,
	input wire logic sigSerialOut,
	output logic [7:0] lineByte
);
	// =====================================================
	// Word timing and line capture.
	logic [7:0] phase; // Clocks into the core's current word.
	logic [7:0] phaseNext; // Phase after this clock.
	logic [7:0] shiftReg; // Bits caught so far, first bit highest.
	logic runQ; // Run seen last clock, to find its start.
	logic wordEnd; // Last clock of a word.
	assign wordEnd = phase == 8'(8 * BIT_DIV - 1);
	// The phase starts one slot and a clock before zero, so that zero is
	// the clock at which the core's first slot opens.
	assign phaseNext = !runQ ? 8'(7 * BIT_DIV - 1) :
		wordEnd ? 8'h00 : phase + 8'h01;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= 8'h00;
			shiftReg <= 8'h00;
			runQ <= 1'b0;
			frameSync <= 1'b0;
			masterFramePulse <= 1'b0;
			sigSerialIn <= 1'b0;
			lineByte <= 8'h00;
		end else begin
			runQ <= run;
			// A new run restarts the word index as well as the slots.
			masterFramePulse <= run && !runQ;
			// One sync per run: a sync in every word would land on a slot
			// edge and cost the core one tick per word.
			frameSync <= run && !runQ;
			phase <= phaseNext;
			// Idle line sits low; each bit stands when the core samples it.
			sigSerialIn <= run && IN_BYTE[3'(7 - phaseNext / BIT_DIV)];
			// Sample in mid-slot, away from the core's own edges.
			if (runQ && phase % BIT_DIV == BIT_DIV / 2) begin
				shiftReg <= {shiftReg[6:0], sigSerialOut};
			end
			if (runQ && phase == 8'(8 * BIT_DIV - BIT_DIV / 2)) begin
				lineByte <= {shiftReg[6:0], sigSerialOut};
			end
		end
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the signaling core with a time switch model.
// Assumes header, package, buffer, core, checker and model compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "abs_defines.svh"

module tb_top;
	// =====================================================
	// Stimulus and observed signals.
	localparam int AW = 2; // Four words a region keeps frames short.
	localparam logic [2:0] BOARD = 3'h5; // This card's board number.
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic masterResetN = 1'b1;
	logic [20:0] hostAddr = '0;
	logic [7:0] hostDrv = '0;
	logic addrValidStrobeN = 1'b1, upperByteStrobeN = 1'b1;
	logic lowerByteStrobeN = 1'b1, hostRead = 1'b0;
	logic upReq = 1'b0, upWrite = 1'b0, run = 1'b0;
	logic [3:0] upAddr = '0;
	logic [7:0] upWrData = '0, hostDataOut, upRdData, lineByte;
	logic hostDataOe, transferAckN, upAck, sigSerialOut, sigSerialIn;
	logic frameSync, masterFramePulse;
	int nFail = 0, samplesChecked = 0;
	wire logic [7:0] dataBus;
	// The card's drive wins only while it enables it.
	assign dataBus = hostDataOe ? hostDataOut : hostDrv;
	always #5 clk = ~clk;
	abs_ab_signaling #(.AW(AW), .A_WORDS(2), .BIT_DIV(8), .BOARD_W(3)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1),
		.masterResetN(masterResetN), .frameSync(frameSync),
		.masterFramePulse(masterFramePulse), .hostAddr(hostAddr),
		.hostDataIn(dataBus), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe), .addrValidStrobeN(addrValidStrobeN),
		.upperByteStrobeN(upperByteStrobeN), .lowerByteStrobeN(lowerByteStrobeN),
		.hostRead(hostRead), .transferAckN(transferAckN),
		.boardSelectBits(BOARD), .upReq(upReq), .upWrite(upWrite),
		.upAddr(upAddr), .upWrData(upWrData), .upRdData(upRdData),
		.upAck(upAck), .sigSerialOut(sigSerialOut), .sigSerialIn(sigSerialIn));
	abs_time_switch_model #(.BIT_DIV(8), .IN_BYTE(8'hC6)) model_u (.clk(clk),
		.sys_rst(sys_rst),
		.run(run), .frameSync(frameSync), .masterFramePulse(masterFramePulse),
		.sigSerialIn(sigSerialIn), .sigSerialOut(sigSerialOut),
		.lineByte(lineByte));
	// =====================================================
	// Comparison, verdict and bus cycles.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nFail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic closeOut();
		$display("mismatches=%0d comparisons=%0d", nFail, samplesChecked);
		if (nFail == 0 && samplesChecked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// One host byte; reads use the lower strobe, writes the upper one.
	task automatic hx(input logic [2:0] b, input logic rd, input logic [1:0] rg,
			input logic [1:0] w, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		hostAddr <= {b, 8'h00, rg, 6'h00, w};
		hostRead <= rd;
		hostDrv <= rd ? ~d : d;
		addrValidStrobeN <= 1'b0;
		if (rd) lowerByteStrobeN <= 1'b0;
		else upperByteStrobeN <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (transferAckN !== 1'b0 && n < 9);
		q = hostDataOut;
		check({7'h00, transferAckN}, 8'h00);
		addrValidStrobeN <= 1'b1;
		upperByteStrobeN <= 1'b1;
		lowerByteStrobeN <= 1'b1;
		repeat (2) @(posedge clk);
		check({7'h00, transferAckN}, 8'h01);
	endtask
	// One microprocessor access, request held until answered.
	task automatic ux(input logic wr, input logic [3:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		n = 0;
		upReq <= 1'b1;
		upWrite <= wr;
		upAddr <= a;
		upWrData <= d;
		do begin
			@(posedge clk);
			n++;
		end while (upAck !== 1'b1 && n < 9);
		q = upRdData;
		check({7'h00, upAck}, 8'h01);
		upReq <= 1'b0;
		@(posedge clk);
	endtask
	// =====================================================
	// Scenarios.
	task automatic cmdScenario();
		logic [7:0] q;
		hx(BOARD, 1'b0, `ABS_REG_CMD, 2'h1, 8'h5A, q);
		ux(1'b0, {`ABS_REG_CMD, 2'h1}, 8'h00, q);
		check(q, 8'h5A);
		ux(1'b1, {`ABS_REG_CMD, 2'h2}, 8'hC3, q);
		hx(BOARD, 1'b1, `ABS_REG_CMD, 2'h2, 8'h00, q);
		check(q, 8'hC3);
	endtask
	// Another board's address must draw no answer at all.
	task automatic refuseScenario();
		logic [7:0] q;
		hostAddr <= {3'h2, 18'h00000};
		addrValidStrobeN <= 1'b0;
		lowerByteStrobeN <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			check({7'h00, transferAckN}, 8'h01);
		end
		addrValidStrobeN <= 1'b1;
		lowerByteStrobeN <= 1'b1;
		@(posedge clk);
		hx(BOARD, 1'b1, 2'h3, 2'h0, 8'h00, q);
		check(q, `ABS_UNMAPPED);
	endtask
	// Both sides write one word in one contested cycle; the later grant
	// leaves its value. The host wins the first contest, then the other.
	task automatic contendScenario();
		logic [7:0] q1, q2;
		fork
			hx(BOARD, 1'b0, `ABS_REG_CMD, 2'h0, 8'h11, q1);
			begin
				@(posedge clk);
				ux(1'b1, {`ABS_REG_CMD, 2'h0}, 8'h22, q2);
			end
		join
		hx(BOARD, 1'b1, `ABS_REG_CMD, 2'h0, 8'h00, q1);
		check(q1, 8'h22);
		fork
			hx(BOARD, 1'b0, `ABS_REG_CMD, 2'h3, 8'h33, q1);
			begin
				@(posedge clk);
				ux(1'b1, {`ABS_REG_CMD, 2'h3}, 8'h44, q2);
			end
		join
		ux(1'b0, {`ABS_REG_CMD, 2'h3}, 8'h00, q2);
		check(q2, 8'h33);
	endtask
	task automatic serialScenario();
		logic [7:0] q;
		for (int i = 0; i < 3; i++) begin
			hx(BOARD, 1'b0, `ABS_REG_OUT, 2'(i), 8'hC4, q);
		end
		ux(1'b1, {`ABS_REG_OUT, 2'h3}, 8'h1E, q);
		hx(BOARD, 1'b1, `ABS_REG_CMD, 2'h1, 8'h00, q);
		check(q, 8'h5A);
		run <= 1'b1;
		// Word n is caught 71 + 64 * n clocks after the run starts, so
		// these two looks see words 10 and 11, outgoing indices 2 and 3.
		repeat (736) @(posedge clk);
		check(lineByte, 8'hC4);
		repeat (64) @(posedge clk);
		check(lineByte, 8'h1E);
		hx(BOARD, 1'b1, `ABS_REG_IN, 2'h0, 8'h00, q);
		check(q, 8'hC6);
		hx(BOARD, 1'b1, `ABS_REG_IN, 2'h3, 8'h00, q);
		check(q, 8'hC6);
		ux(1'b0, {`ABS_REG_IN, 2'h3}, 8'h00, q);
		check(q, 8'hC6);
	endtask
	// Master reset silences the line but keeps the RAM contents.
	task automatic masterScenario();
		logic [7:0] q;
		masterResetN <= 1'b0;
		@(posedge clk);
		repeat (2) begin
			@(posedge clk);
			check({7'h00, sigSerialOut}, 8'h00);
		end
		masterResetN <= 1'b1;
		run <= 1'b0;
		@(posedge clk);
		hx(BOARD, 1'b1, `ABS_REG_CMD, 2'h2, 8'h00, q);
		check(q, 8'hC3);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		cmdScenario();
		refuseScenario();
		contendScenario();
		serialScenario();
		masterScenario();
		closeOut();
	end
	// A hang is cut off long after the scenarios should have ended.
	initial begin
		repeat (5000) @(posedge clk);
		nFail++;
		closeOut();
	end
endmodule
`default_nettype wire
